// ==== pkg/flash_prot_cfg.svh ====
/*
 * Constants for the sector protection decoder: opcodes, status byte fields,
 * register offsets and reset values.
 * Assumes it is included by bare name wherever a constant is needed.
 */
`ifndef FLASH_PROT_CFG_SVH
`define FLASH_PROT_CFG_SVH

// ============================================================================
// Serial command opcodes
`define OP_WRITE_STATUS   8'h01
`define OP_WRITE_DISABLE  8'h04
`define OP_WRITE_ENABLE   8'h06

// ============================================================================
// Status byte fields
`define SB_LOCK_BIT       7
`define SB_GLOBAL_HI      5
`define SB_GLOBAL_LO      2
`define GLOBAL_ALL_ONES   4'hf
`define GLOBAL_ALL_ZEROS  4'h0

// ============================================================================
// Sector count and reset values
`define SECTOR_COUNT      16
`define SECTOR_RESET      16'hffff
`define BIT_CNT_ZERO      3'h0
`define BIT_CNT_LAST      3'h7

// ============================================================================
// APB register map, byte addresses
`define ADDR_STATUS       12'h000
`define ADDR_SECT_CTRL    12'h004
`define STAT_LOCK_POS     16
`define STAT_WEL_POS      17
`define STAT_WP_POS       18
`define CTRL_VALUE_POS    4
`define CTRL_INDEX_HI     3
`define CTRL_INDEX_LO     0

`endif

// ==== pkg/flash_prot_pkg.sv ====
/*
 * Types shared by the sector protection decoder.
 * Assumes flash_prot_cfg.svh supplies the numeric constants.
 */
`include "flash_prot_cfg.svh"

package flash_prot_pkg;

    typedef logic [`SECTOR_COUNT-1:0] sect_t;
    typedef logic [7:0]               byte_t;

    // Frame progress, one-hot.
    typedef enum logic [3:0] {
        ST_CMD  = 4'b0001,
        ST_DATA = 4'b0010,
        ST_HAVE = 4'b0100,
        ST_SKIP = 4'b1000
    } frame_e;

endpackage

// ==== hw/spi_byte_rx.sv ====
/*
 * Serial byte receiver: samples mosi on rising sck while cs_n is low and
 * emits each completed byte as a one-cycle pulse.
 * Assumes sck, cs_n and mosi are synchronous to pclk and sck is slower than
 * half the pclk rate (mode 0 or 3).
 */
`timescale 1ns/1ns
`include "flash_prot_cfg.svh"

module spi_byte_rx (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 sck,
    input  wire logic                 cs_n,
    input  wire logic                 mosi,
    output logic                      byte_valid,
    output flash_prot_pkg::byte_t     byte_data,
    output logic [2:0]                bit_cnt
);
    import flash_prot_pkg::*;

    logic   sck_q, sck_d;
    byte_t  shift_q, shift_d;
    logic   [2:0] cnt_q, cnt_d;
    logic   valid_q, valid_d;
    byte_t  data_q, data_d;
    logic   rise;

    always_comb begin
        rise    = sck & ~sck_q & ~cs_n;
        sck_d   = sck;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        valid_d = 1'b0;
        data_d  = data_q;
        if (cs_n) begin
            cnt_d = `BIT_CNT_ZERO;
        end else if (rise) begin
            shift_d = {shift_q[6:0], mosi};
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == `BIT_CNT_LAST) begin
                valid_d = 1'b1;
                data_d  = {shift_q[6:0], mosi};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sck_q   <= 1'b0;
            shift_q <= 8'h00;
            cnt_q   <= `BIT_CNT_ZERO;
            valid_q <= 1'b0;
            data_q  <= 8'h00;
        end else begin
            sck_q   <= sck_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
            valid_q <= valid_d;
            data_q  <= data_d;
        end
    end

    assign byte_valid = valid_q;
    assign byte_data  = data_q;
    assign bit_cnt    = cnt_q;

endmodule // spi_byte_rx

// ==== hw/global_sector_protect_decode.sv ====
/*
 * Global protect / unprotect decoder with sector lock handling, fed by the
 * serial status write, plus an APB view of the protection state.
 * Assumes serial pins are synchronous to pclk and that one APB master drives
 * the register port.
 */
`timescale 1ns/1ns
`include "flash_prot_cfg.svh"

module global_sector_protect_decode (
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 sck,
    input  wire logic                 cs_n,
    input  wire logic                 mosi,
    input  wire logic                 wp_n,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic [31:0]               prdata,
    output logic                      pready,
    output logic                      pslverr,
    output flash_prot_pkg::sect_t     sector_protect,
    output logic                      sector_lock_bit,
    output logic                      write_latch_bit
);
    import flash_prot_pkg::*;

    // ========================================================================
    // Serial byte capture
    logic        byte_valid;
    byte_t       byte_data;
    logic [2:0]  bit_cnt;

    spi_byte_rx u_rx (
        .pclk       (pclk),
        .presetn    (presetn),
        .sck        (sck),
        .cs_n       (cs_n),
        .mosi       (mosi),
        .byte_valid (byte_valid),
        .byte_data  (byte_data),
        .bit_cnt    (bit_cnt)
    );

    // ========================================================================
    // Frame tracking
    frame_e  st_q, st_d;
    byte_t   op_q, op_d;
    byte_t   dat_q, dat_d;
    logic    cs_q, cs_d;
    logic    frame_end;
    logic    aligned;

    always_comb begin
        st_d      = st_q;
        op_d      = op_q;
        dat_d     = dat_q;
        cs_d      = cs_n;
        frame_end = cs_n & ~cs_q;
        aligned   = (bit_cnt == `BIT_CNT_ZERO);
        if (frame_end) begin
            st_d = ST_CMD;
        end else if (byte_valid) begin
            unique case (st_q)
                ST_CMD: begin
                    op_d = byte_data;
                    st_d = (byte_data == `OP_WRITE_STATUS) ? ST_DATA : ST_SKIP;
                end
                ST_DATA: begin
                    dat_d = byte_data;
                    st_d  = ST_HAVE;
                end
                ST_HAVE: begin
                    st_d = ST_HAVE;
                end
                ST_SKIP: begin
                    st_d = ST_SKIP;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q  <= ST_CMD;
            op_q  <= 8'h00;
            dat_q <= 8'h00;
            cs_q  <= 1'b1;
        end else begin
            st_q  <= st_d;
            op_q  <= op_d;
            dat_q <= dat_d;
            cs_q  <= cs_d;
        end
    end

    // ========================================================================
    // Protection state
    // A frame cut off mid-byte, or a status write missing its data byte,
    // changes nothing, so a glitch on chip select cannot unlock the array.
    sect_t   sect_q, sect_d;
    logic    lock_q, lock_d;
    logic    wel_q, wel_d;
    logic    wr_status;
    logic    hard_lock;
    logic [3:0] glob;
    logic    ctrl_wr;
    logic [3:0] ctrl_idx;

    always_comb begin
        sect_d    = sect_q;
        lock_d    = lock_q;
        wel_d     = wel_q;
        glob      = dat_q[`SB_GLOBAL_HI:`SB_GLOBAL_LO];
        hard_lock = lock_q & ~wp_n;
        wr_status = frame_end & aligned & (st_q == ST_HAVE);
        ctrl_wr   = psel & penable & pwrite & (paddr == `ADDR_SECT_CTRL);
        ctrl_idx  = pwdata[`CTRL_INDEX_HI:`CTRL_INDEX_LO];
        if (frame_end & aligned & (st_q == ST_SKIP)) begin
            if (op_q == `OP_WRITE_ENABLE) begin
                wel_d = 1'b1;
            end else if (op_q == `OP_WRITE_DISABLE) begin
                wel_d = 1'b0;
            end
        end
        if (wr_status & wel_q) begin
            wel_d = 1'b0;
            if (!hard_lock) begin
                lock_d = dat_q[`SB_LOCK_BIT];
            end
            if (!lock_q) begin
                if (glob == `GLOBAL_ALL_ONES) begin
                    sect_d = `SECTOR_RESET;
                end else if (glob == `GLOBAL_ALL_ZEROS) begin
                    sect_d = '0;
                end
            end
        end
        // Single sector access stays live after any global operation; a set
        // lock bit freezes it like the global path.
        if (ctrl_wr & !lock_q) begin
            sect_d[ctrl_idx] = pwdata[`CTRL_VALUE_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sect_q <= `SECTOR_RESET;
            lock_q <= 1'b0;
            wel_q  <= 1'b0;
        end else begin
            sect_q <= sect_d;
            lock_q <= lock_d;
            wel_q  <= wel_d;
        end
    end

    // ========================================================================
    // APB slave, zero wait states, read data registered in the setup cycle
    logic [31:0] rdata_q, rdata_d;
    logic        mapped;

    always_comb begin
        mapped  = (paddr == `ADDR_STATUS) | (paddr == `ADDR_SECT_CTRL);
        rdata_d = rdata_q;
        if (psel & ~penable) begin
            rdata_d = 32'h0000_0000;
            if (paddr == `ADDR_STATUS) begin
                rdata_d[`SECTOR_COUNT-1:0] = sect_q;
                rdata_d[`STAT_LOCK_POS]    = lock_q;
                rdata_d[`STAT_WEL_POS]     = wel_q;
                rdata_d[`STAT_WP_POS]      = wp_n;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign prdata          = rdata_q;
    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~mapped;
    assign sector_protect  = sect_q;
    assign sector_lock_bit = lock_q;
    assign write_latch_bit = wel_q;

endmodule // global_sector_protect_decode

// ==== testbench/global_sector_protect_decode_asserts.sv ====
/* Port checker for the global sector protect decoder.
   Assumes it is bound to the top module and sees its ports only. */
`timescale 1ns/1ns
module global_sector_protect_decode_asserts (
    input logic                  pclk,
    input logic                  presetn,
    input logic                  sck,
    input logic                  cs_n,
    input logic                  mosi,
    input logic                  wp_n,
    input logic                  psel,
    input logic                  penable,
    input logic                  pwrite,
    input logic [11:0]           paddr,
    input logic [31:0]           pwdata,
    input logic [31:0]           prdata,
    input logic                  pready,
    input logic                  pslverr,
    input flash_prot_pkg::sect_t sector_protect,
    input logic                  sector_lock_bit,
    input logic                  write_latch_bit
);
    import flash_prot_pkg::*;
    // ========================================================================
    // Frame end marker: high one edge after chip select is seen released.
    logic [1:0] cs_q;
    logic       fe;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) cs_q <= 2'b11;
        else cs_q <= {cs_q[0], cs_n};
    end
    assign fe = cs_q[0] & ~cs_q[1];
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ========================================================================
    // Properties
    property p_glob_only;
        $changed(sector_protect) && !$past(psel && penable && pwrite)
            |-> sector_protect inside {16'hffff, 16'h0000};
    endproperty
    a_glob_only: assert property (p_glob_only)
        else $error("serial update was not a whole-array value");
    property p_prot_at_end;
        $changed(sector_protect) |-> fe || $past(psel && penable && pwrite);
    endproperty
    a_prot_at_end: assert property (p_prot_at_end)
        else $error("sectors changed outside a frame end");
    property p_lock_at_end;
        $changed(sector_lock_bit) |-> fe;
    endproperty
    a_lock_at_end: assert property (p_lock_at_end)
        else $error("lock changed outside a frame end");
    property p_latch_at_end;
        $changed(write_latch_bit) |-> fe;
    endproperty
    a_latch_at_end: assert property (p_latch_at_end)
        else $error("latch changed outside a frame end");
    property p_lock_wp;
        $fell(sector_lock_bit) |-> $past(wp_n);
    endproperty
    a_lock_wp: assert property (p_lock_wp)
        else $error("lock cleared with the pin low");
    property p_lock_hold;
        $past(sector_lock_bit) |-> $stable(sector_protect);
    endproperty
    a_lock_hold: assert property (p_lock_hold)
        else $error("sectors changed while locked");
    property p_lock_latch;
        $changed(sector_lock_bit) |-> $past(write_latch_bit);
    endproperty
    a_lock_latch: assert property (p_lock_latch)
        else $error("lock changed without the latch");
    property p_glob_latch;
        $changed(sector_protect) && fe && !$past(psel && penable && pwrite)
            |-> $past(write_latch_bit) && !$past(sector_lock_bit);
    endproperty
    a_glob_latch: assert property (p_glob_latch)
        else $error("global update without latch or while locked");
    c_lock_set: cover property ($rose(sector_lock_bit));
    c_lock_clr: cover property ($fell(sector_lock_bit));
    c_slverr: cover property (psel && penable && pslverr);
endmodule // global_sector_protect_decode_asserts

// ==== testbench/spi_host_model.sv ====
/* Serial host model that clocks framed commands into the decoder.
   Assumes mode 0 and a caller that issues one frame at a time. */
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic pclk,
    output logic      sck,
    output logic      cs_n,
    output logic      mosi
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // Sends the top n bits of w, MSB first; short n leaves a broken frame.
    task automatic frame(input logic [15:0] w, input int n);
        @(posedge pclk) cs_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            @(posedge pclk) begin sck <= 1'b0; mosi <= w[i]; end
            repeat (2) @(posedge pclk);
            sck <= 1'b1;
            repeat (2) @(posedge pclk);
        end
        // Released data shows the inverse so a stale bit is never trusted.
        @(posedge pclk) begin sck <= 1'b0; mosi <= ~mosi; end
        repeat (2) @(posedge pclk);
        cs_n <= 1'b1;
        repeat (3) @(posedge pclk);
    endtask
endmodule // spi_host_model

// ==== testbench/global_sector_protect_decode_tb.sv ====
/* Self-checking bench: serial status writes and APB reads of the state.
   Assumes the design, its package and the serial host model are compiled. */
`timescale 1ns/1ns
`include "flash_prot_cfg.svh"
module global_sector_protect_decode_tb;
    import flash_prot_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, wp_n = 1'b1;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h0000a35e;
    logic pready, pslverr, sck, cs_n, mosi, lock = 1'b0, latch = 1'b0;
    sect_t sect = 16'hffff, sector_protect;
    logic sector_lock_bit, write_latch_bit;
    logic [32:0] q[$];
    int mismatches = 0, n_tests = 0;
    spi_host_model host (.pclk, .sck, .cs_n, .mosi);
    global_sector_protect_decode dut (.pclk, .presetn, .sck, .cs_n, .mosi, .wp_n,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .sector_protect, .sector_lock_bit, .write_latch_bit);
    initial forever #50 pclk = ~pclk;
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk) begin psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; end
        @(posedge pclk) penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic rd_st(input string s);
        rd(`ADDR_STATUS, {14'h0, wp_n, latch, lock, sect});
        check({15'h0, write_latch_bit, sector_lock_bit, sector_protect},
              {15'h0, latch, lock, sect});
        $display("test %s done", s);
    endtask
    task automatic wen();
        host.frame({`OP_WRITE_ENABLE, 8'h00}, 8);
        latch = 1'b1;
    endtask
    task automatic sw(input logic [7:0] d);
        host.frame({`OP_WRITE_STATUS, d}, 16);
        if (latch && (!lock || wp_n)) begin
            if (!lock && d[5:2] == 4'hf) sect = 16'hffff;
            if (!lock && d[5:2] == 4'h0) sect = 16'h0000;
            lock = d[7];
        end
        latch = 1'b0;
    endtask
    task automatic sct(input logic [3:0] i, input logic v);
        apb(1'b1, `ADDR_SECT_CTRL, {27'h0, v, i});
        if (!lock) sect[i] = v;
    endtask
    // ========================================================================
    // Monitor: every completed read is matched against the oldest note.
    always @(posedge pclk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, q.pop_front());
    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        finish_test();
    end
    // ========================================================================
    // Main sequence
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        rd_st("reset");
        sw(8'h00);
        rd_st("no latch");
        for (int i = 0; i < 31; i++) begin
            r = xs();
            wen();
            sw({1'b0, r[6], 4'((i + 1) & 15), r[1:0]});
            rd_st("global decode");
        end
        sct(4'h3, 1'b1);
        wen();
        sw(8'h7f);
        sct(4'h5, 1'b0);
        rd_st("single sectors");
        wen();
        sw(8'hff);
        rd_st("lock with protect");
        wen();
        sw(8'h00);
        rd_st("soft unlock");
        wen();
        sw(8'hc3);
        wp_n <= 1'b0;
        wen();
        sw(8'h3c);
        sct(4'h2, 1'b1);
        rd_st("hard lock");
        wen();
        host.frame(16'h01ff, 12);
        rd_st("broken frame");
        host.frame({`OP_WRITE_DISABLE, 8'h00}, 8);
        latch = 1'b0;
        rd_st("write disable");
        rd(12'h008, {1'b1, 32'h0});
        rd(`ADDR_SECT_CTRL, 33'h0);
        @(posedge pclk) presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        sect = 16'hffff;
        lock = 1'b0;
        rd_st("second reset");
        finish_test();
    end
endmodule // global_sector_protect_decode_tb
bind global_sector_protect_decode global_sector_protect_decode_asserts u_chk (
    .pclk, .presetn, .sck, .cs_n, .mosi, .wp_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sector_protect,
    .sector_lock_bit, .write_latch_bit);
